/* File: hw/isp_pkg.sv */
package isp_pkg;
   localparam int unsigned CLK_PERIOD_NS = 10;

   // Least time rounds up, never below one cycle
   function automatic int unsigned cyc_min(input int unsigned ns);
      int unsigned c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int unsigned T_PWRUP_NS = 10000;
   localparam int unsigned PWRUP_CYC = cyc_min(T_PWRUP_NS);
   localparam int unsigned T_SCK_NS = 200;
   localparam int unsigned SCK_HALF_CYC = cyc_min(T_SCK_NS / 2);
   localparam int unsigned T_SSD_NS = 50;
   localparam int unsigned SSD_CYC = cyc_min(T_SSD_NS);
   localparam int unsigned T_SSZ_NS = 25;
   localparam int unsigned SSZ_CYC = cyc_min(T_SSZ_NS);
   // Worst case reset-low to tristate is two slowest system clocks
   localparam int unsigned T_RLZ_NS = 120;
   localparam int unsigned T_STL_NS = 100;
   localparam int unsigned ENTRY_CYC = cyc_min(T_RLZ_NS + T_STL_NS);
   localparam int unsigned T_WR_US = 2500;
   localparam int unsigned T_WR_AE_US = 5000;
   localparam int unsigned T_ERS_US = 7500;
   localparam int unsigned T_STARTUP_US = 16000;
   localparam int unsigned WR_CYC_DEF = cyc_min(T_WR_US * 1000);
   localparam int unsigned WR_AE_CYC_DEF = cyc_min(T_WR_AE_US * 1000);
   localparam int unsigned ERS_CYC_DEF = cyc_min(T_ERS_US * 1000);
   localparam int unsigned STARTUP_CYC_DEF = cyc_min(T_STARTUP_US * 1000);
   localparam logic [1:0] BOOT_CYC = 2'h3;
   localparam logic [7:0] RX_RST = 8'h00;

   typedef enum logic [1:0] {
      CMD_PWRUP = 2'h0,
      CMD_START = 2'h1,
      CMD_EXIT = 2'h2,
      CMD_PWRDN = 2'h3
   } isp_cmd_t;

   typedef enum logic [1:0] {
      WAIT_NONE = 2'h0,
      WAIT_WR = 2'h1,
      WAIT_WR_AE = 2'h2,
      WAIT_ERS = 2'h3
   } isp_wait_t;
endpackage

/* File: hw/isp_if.sv */
interface isp_if;
   logic power_en;
   logic rst_out;
   logic rst_oe_n;
   logic ss_out;
   logic ss_oe_n;
   logic sck_out;
   logic sck_oe_n;
   logic mosi_out;
   logic mosi_oe_n;
   logic miso_out;
   logic miso_oe_n;
   logic rst_lvl;
   logic ss_lvl;
   logic sck_lvl;
   logic mosi_lvl;
   logic miso_lvl;

   // Reset, select and MISO lines have pull-ups; clock and MOSI idle low
   assign rst_lvl = rst_oe_n ? 1'b1 : rst_out;
   assign ss_lvl = ss_oe_n ? 1'b1 : ss_out;
   assign sck_lvl = sck_oe_n ? 1'b0 : sck_out;
   assign mosi_lvl = mosi_oe_n ? 1'b0 : mosi_out;
   assign miso_lvl = miso_oe_n ? 1'b1 : miso_out;

   modport dev (
      input rst_lvl, ss_lvl, sck_lvl, mosi_lvl, power_en,
      output miso_out, miso_oe_n
   );
   modport prg (
      input miso_lvl,
      output power_en, rst_out, rst_oe_n, ss_out, ss_oe_n,
      output sck_out, sck_oe_n, mosi_out, mosi_oe_n
   );
endinterface

/* File: hw/isp_dev.sv */
module isp_dev
   import isp_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   isp_if.dev link,
   input wire logic cfg_rst_pin_en_i,
   input wire logic cfg_isp_en_i,
   input wire logic [7:0] tx_data_i,
   input wire logic tx_load_i,
   output logic [7:0] rx_data_o,
   output logic rx_valid_o,
   output logic prog_mode_o,
   output logic cpu_run_o,
   output logic io_tristate_o
);

   typedef enum logic [1:0] {
      DS_BOOT = 2'h0,
      DS_RUN = 2'h1,
      DS_PROG = 2'h2
   } isp_dstate_t;

   typedef struct packed {
      isp_dstate_t state;
      logic [1:0] boot_cnt;
      logic rst_s1;
      logic rst_s2;
      logic ss_s1;
      logic ss_s2;
      logic tg_s1;
      logic tg_s2;
      logic tg_d;
      logic rst_en;
      logic isp_en;
      logic io_hiz;
      logic cpu_run;
      logic prog;
      logic miso_oe_n;
      logic [7:0] rx_data;
      logic rx_valid;
      logic [7:0] tx_hold;
   } isp_sys_t;

   typedef struct packed {
      logic [2:0] cnt;
      logic [7:0] sh;
      logic [7:0] rx_hold;
      logic tgl;
   } isp_lpos_t;

   typedef struct packed {
      logic [7:0] sh;
   } isp_lneg_t;

   isp_sys_t q_ff;
   isp_sys_t nxt_q;
   isp_lpos_t lp_ff;
   isp_lpos_t nxt_lp;
   isp_lneg_t ln_ff;
   isp_lneg_t nxt_ln;
   logic link_rst_n;

   ////////////////////////////////////////////////////////////////////////////
   // System clock domain: entry, exit and byte hand-off

   always_comb begin
      nxt_q = q_ff;
      nxt_q.rx_valid = 1'b0;
      nxt_q.rst_s1 = link.rst_lvl;
      nxt_q.rst_s2 = q_ff.rst_s1;
      nxt_q.ss_s1 = link.ss_lvl;
      nxt_q.ss_s2 = q_ff.ss_s1;
      nxt_q.tg_s1 = lp_ff.tgl;
      nxt_q.tg_s2 = q_ff.tg_s1;
      nxt_q.tg_d = q_ff.tg_s2;
      unique case (q_ff.state)
         DS_BOOT: begin
            nxt_q.boot_cnt = q_ff.boot_cnt + 2'h1;
            if (q_ff.boot_cnt == BOOT_CYC) begin
               nxt_q.rst_en = cfg_rst_pin_en_i;
               nxt_q.isp_en = cfg_isp_en_i;
               // Power-up entry works whatever the configuration
               if (!q_ff.rst_s2) begin // RULE4
                  nxt_q.state = DS_PROG;
                  nxt_q.prog = 1'b1;
                  nxt_q.io_hiz = 1'b1;
               end else begin
                  nxt_q.state = DS_RUN;
                  nxt_q.cpu_run = 1'b1;
               end
            end
         end
         DS_RUN: begin
            // Pin as general I/O never resets or enters programming
            nxt_q.cpu_run = !(q_ff.rst_en && !q_ff.rst_s2); // RULE4
            if (q_ff.rst_en && q_ff.isp_en && !q_ff.rst_s2) begin // RULE4
               nxt_q.state = DS_PROG;
               nxt_q.prog = 1'b1;
               nxt_q.io_hiz = 1'b1; // RULE7
            end
         end
         DS_PROG: begin
            if (q_ff.rst_s2) begin
               // New pin and programming settings take hold here and at the end of boot
               nxt_q.rst_en = cfg_rst_pin_en_i; // RULE17
               nxt_q.isp_en = cfg_isp_en_i; // RULE17
               nxt_q.state = DS_RUN;
               nxt_q.prog = 1'b0;
               nxt_q.io_hiz = 1'b0;
               nxt_q.cpu_run = 1'b1;
            end
         end
         default: begin
            nxt_q.state = DS_BOOT;
         end
      endcase
      // Slave only drives its output while selected in programming
      nxt_q.miso_oe_n = !(nxt_q.prog && !q_ff.ss_s2); // RULE10
      // Deselect clears the link toggle; that edge carries no byte
      if (q_ff.tg_s2 != q_ff.tg_d && q_ff.prog && !q_ff.ss_s2) begin
         nxt_q.rx_data = lp_ff.rx_hold; // RULE11
         nxt_q.rx_valid = 1'b1;
      end
      if (tx_load_i) begin
         nxt_q.tx_hold = tx_data_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q_ff <= '{state: DS_BOOT, boot_cnt: 2'h0, rst_s1: 1'b1, rst_s2: 1'b1,
                   ss_s1: 1'b1, ss_s2: 1'b1, tg_s1: 1'b0, tg_s2: 1'b0,
                   tg_d: 1'b0, rst_en: 1'b1, isp_en: 1'b1, io_hiz: 1'b0,
                   cpu_run: 1'b0, prog: 1'b0, miso_oe_n: 1'b1,
                   rx_data: RX_RST, rx_valid: 1'b0, tx_hold: RX_RST};
      end else begin
         q_ff <= nxt_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Link clock domain, cleared while deselected

   assign link_rst_n = rst_n_i & ~link.ss_lvl;

   always_comb begin
      nxt_lp = lp_ff;
      nxt_lp.cnt = lp_ff.cnt + 3'h1;
      nxt_lp.sh = {lp_ff.sh[6:0], link.mosi_lvl}; // RULE12 RULE13
      if (lp_ff.cnt == 3'h7) begin
         nxt_lp.rx_hold = {lp_ff.sh[6:0], link.mosi_lvl}; // RULE11
         nxt_lp.tgl = ~lp_ff.tgl;
      end
   end

   always_ff @(posedge link.sck_lvl or negedge link_rst_n) begin
      if (!link_rst_n) begin
         lp_ff <= '{cnt: 3'h0, sh: RX_RST, rx_hold: RX_RST, tgl: 1'b0};
      end else begin
         lp_ff <= nxt_lp;
      end
   end

   // Reply word is quasi-static; it must be loaded before the byte starts
   always_comb begin
      nxt_ln = ln_ff;
      if (lp_ff.cnt == 3'h0) begin
         nxt_ln.sh = q_ff.tx_hold; // RULE11
      end else begin
         nxt_ln.sh = {ln_ff.sh[6:0], 1'b0}; // RULE12 RULE13
      end
   end

   always_ff @(negedge link.sck_lvl or negedge link_rst_n) begin
      if (!link_rst_n) begin
         ln_ff <= '{sh: RX_RST};
      end else begin
         ln_ff <= nxt_ln;
      end
   end

   assign link.miso_out = ln_ff.sh[7];
   assign link.miso_oe_n = q_ff.miso_oe_n;
   assign rx_data_o = q_ff.rx_data;
   assign rx_valid_o = q_ff.rx_valid;
   assign prog_mode_o = q_ff.prog;
   assign cpu_run_o = q_ff.cpu_run;
   assign io_tristate_o = q_ff.io_hiz;
endmodule

/* File: hw/isp_prg.sv */
// Contract
// RULE1: Hold reset low while applying power.
// RULE2: Wait 10 us before raising select.
// RULE3: Wait start-up timeout before the session.
// RULE4: Pin-as-IO or disabled: power-up entry only.
// RULE5: Power-down: clock low, select high, tristate, off.
// RULE6: Running entry: reset low, select high, settle.
// RULE7: Device tristates I/O one to two clocks. The device model sets io_hiz three clocks after reset falls.
// RULE8: Exit: clock low, select high, release reset.
// RULE9: Tristate select within two clocks of reset.
// RULE10: Programmer is master, device is slave.
// RULE11: Device shifts MOSI in, MISO out, bytewise.
// RULE12: Every byte travels most significant bit first.
// RULE13: Mode 0: idle low, sample rising edge.
// RULE14: Serial clock period at least 200 ns.
// RULE15: Wait 2.5 ms after write, 5 ms auto-erase.
// RULE16: Wait 7.5 ms after chip erase.
// RULE17: Pin settings change only when session ends.
// RULE18: Hold clock low between bytes.
module isp_prg
   import isp_pkg::*;
#(
   parameter int unsigned STARTUP_CYC = STARTUP_CYC_DEF,
   parameter int unsigned WR_CYC = WR_CYC_DEF,
   parameter int unsigned WR_AE_CYC = WR_AE_CYC_DEF,
   parameter int unsigned ERS_CYC = ERS_CYC_DEF
)
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   isp_if.prg link,
   input wire isp_cmd_t cmd_i,
   input wire logic cmd_valid_i,
   output logic cmd_ready_o,
   input wire logic [7:0] tx_data_i,
   input wire isp_wait_t tx_wait_i,
   input wire logic tx_valid_i,
   output logic tx_ready_o,
   output logic [7:0] rx_data_o,
   output logic rx_valid_o,
   output logic session_o
);

   typedef enum logic [3:0] {
      PS_OFF = 4'h0,
      PS_PWRUP = 4'h1,
      PS_STARTUP = 4'h2,
      PS_SES = 4'h3,
      PS_XFER = 4'h4,
      PS_HOLD = 4'h5,
      PS_LAG = 4'h6,
      PS_SSZ = 4'h7,
      PS_REL = 4'h8,
      PS_RUN = 4'h9,
      PS_ENT = 4'ha
   } isp_pstate_t;

   typedef struct packed {
      isp_pstate_t state;
      logic [31:0] cnt;
      logic [2:0] bit_idx;
      logic [7:0] sh;
      logic rxb;
      isp_wait_t wait_kind;
      logic exit_pd;
      logic power;
      logic rst_out;
      logic rst_oe_n;
      logic ss_out;
      logic ss_oe_n;
      logic sck;
      logic sck_oe_n;
      logic mosi_oe_n;
      logic miso_s1;
      logic miso_s2;
      logic cmd_rdy;
      logic tx_rdy;
      logic [7:0] rx_data;
      logic rx_valid;
      logic session;
   } isp_prg_t;

   isp_prg_t q_ff;
   isp_prg_t nxt_q;

   // Busy time after a byte that started a write or an erase
   function automatic logic [31:0] hold_len(input isp_wait_t w);
      logic [31:0] r;
      r = 32'h1;
      unique case (w)
         WAIT_NONE: r = 32'h1;
         WAIT_WR: r = WR_CYC;
         WAIT_WR_AE: r = WR_AE_CYC;
         WAIT_ERS: r = ERS_CYC;
      endcase
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer and byte engine

   always_comb begin
      nxt_q = q_ff;
      nxt_q.rx_valid = 1'b0;
      nxt_q.miso_s1 = link.miso_lvl;
      nxt_q.miso_s2 = q_ff.miso_s1;
      nxt_q.cnt = q_ff.cnt + 32'h1;
      unique case (q_ff.state)
         PS_OFF: begin
            nxt_q.rst_oe_n = 1'b1;
            if (cmd_valid_i && cmd_i == CMD_PWRUP) begin
               nxt_q.power = 1'b1;
               nxt_q.rst_oe_n = 1'b0; // RULE1
               nxt_q.rst_out = 1'b0; // RULE1
               nxt_q.ss_oe_n = 1'b0;
               nxt_q.ss_out = 1'b0;
               nxt_q.sck_oe_n = 1'b0;
               nxt_q.sck = 1'b0;
               nxt_q.cnt = 32'h0;
               nxt_q.state = PS_PWRUP;
            end
         end
         PS_PWRUP: begin
            if (q_ff.cnt == PWRUP_CYC - 1) begin
               nxt_q.ss_out = 1'b1; // RULE2
               nxt_q.cnt = 32'h0;
               nxt_q.state = PS_STARTUP;
            end
         end
         PS_STARTUP: begin
            // Device power-on reset must finish first
            if (q_ff.cnt == STARTUP_CYC - 1) begin // RULE3
               nxt_q.ss_out = 1'b0;
               nxt_q.mosi_oe_n = 1'b0;
               nxt_q.session = 1'b1;
               nxt_q.state = PS_SES;
            end
         end
         PS_SES: begin
            // Clock stays low while idle between bytes
            nxt_q.sck = 1'b0; // RULE18 RULE13
            if (tx_valid_i) begin
               nxt_q.sh = tx_data_i; // RULE10
               nxt_q.wait_kind = tx_wait_i;
               nxt_q.bit_idx = 3'h0;
               nxt_q.cnt = 32'h0;
               nxt_q.state = PS_XFER;
            end else if (cmd_valid_i && (cmd_i == CMD_EXIT || cmd_i == CMD_PWRDN)) begin
               nxt_q.exit_pd = (cmd_i == CMD_PWRDN);
               nxt_q.cnt = 32'h0;
               nxt_q.state = PS_LAG;
            end
         end
         PS_XFER: begin
            // Two half periods together meet the least clock period
            if (q_ff.cnt == SCK_HALF_CYC - 1) begin // RULE14
               nxt_q.cnt = 32'h0;
               if (!q_ff.sck) begin
                  nxt_q.sck = 1'b1;
                  nxt_q.rxb = q_ff.miso_s2; // RULE13
               end else begin
                  nxt_q.sck = 1'b0;
                  nxt_q.sh = {q_ff.sh[6:0], q_ff.rxb}; // RULE12
                  nxt_q.bit_idx = q_ff.bit_idx + 3'h1;
                  if (q_ff.bit_idx == 3'h7) begin
                     nxt_q.rx_data = {q_ff.sh[6:0], q_ff.rxb};
                     nxt_q.rx_valid = 1'b1;
                     nxt_q.state = (q_ff.wait_kind == WAIT_NONE) ? PS_SES : PS_HOLD;
                  end
               end
            end
         end
         PS_HOLD: begin
            // No access until the memory operation has had its time
            if (q_ff.cnt == hold_len(q_ff.wait_kind) - 32'h1) begin // RULE15 RULE16
               nxt_q.state = PS_SES;
            end
         end
         PS_LAG: begin
            if (q_ff.cnt == SSD_CYC - 1) begin
               nxt_q.ss_out = 1'b1; // RULE5 RULE8
               nxt_q.mosi_oe_n = 1'b1; // RULE5 RULE8
               nxt_q.cnt = 32'h0;
               nxt_q.state = PS_SSZ;
            end
         end
         PS_SSZ: begin
            if (q_ff.cnt == SSZ_CYC - 1) begin
               nxt_q.sck_oe_n = 1'b1;
               nxt_q.session = 1'b0;
               if (q_ff.exit_pd) begin
                  // Supply removed at once, well inside the limit
                  nxt_q.ss_oe_n = 1'b1; // RULE5
                  nxt_q.power = 1'b0; // RULE5
                  nxt_q.state = PS_OFF;
               end else begin
                  nxt_q.rst_oe_n = 1'b1; // RULE8
                  nxt_q.state = PS_REL;
               end
            end
         end
         PS_REL: begin
            nxt_q.ss_oe_n = 1'b1; // RULE9
            nxt_q.state = PS_RUN;
         end
         PS_RUN: begin
            if (cmd_valid_i && cmd_i == CMD_START) begin
               nxt_q.rst_oe_n = 1'b0; // RULE6
               nxt_q.rst_out = 1'b0; // RULE6
               nxt_q.cnt = 32'h0;
               nxt_q.state = PS_ENT;
            end else if (cmd_valid_i && cmd_i == CMD_PWRDN) begin
               nxt_q.power = 1'b0;
               nxt_q.state = PS_OFF;
            end
         end
         PS_ENT: begin
            // Select follows reset by one cycle, then settle
            if (q_ff.cnt == 32'h0) begin
               nxt_q.ss_oe_n = 1'b0; // RULE6
               nxt_q.ss_out = 1'b1; // RULE6
               nxt_q.sck_oe_n = 1'b0;
               nxt_q.sck = 1'b0;
            end
            if (q_ff.cnt == ENTRY_CYC) begin // RULE6
               nxt_q.ss_out = 1'b0;
               nxt_q.mosi_oe_n = 1'b0;
               nxt_q.session = 1'b1;
               nxt_q.state = PS_SES;
            end
         end
         default: begin
            nxt_q.state = PS_OFF;
         end
      endcase
      nxt_q.cmd_rdy = (nxt_q.state == PS_OFF) || (nxt_q.state == PS_RUN) ||
                      (nxt_q.state == PS_SES);
      nxt_q.tx_rdy = (nxt_q.state == PS_SES);
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q_ff <= '{state: PS_OFF, cnt: 32'h0, bit_idx: 3'h0, sh: RX_RST, rxb: 1'b0,
                   wait_kind: WAIT_NONE, exit_pd: 1'b0, power: 1'b0,
                   rst_out: 1'b0, rst_oe_n: 1'b1, ss_out: 1'b1, ss_oe_n: 1'b1,
                   sck: 1'b0, sck_oe_n: 1'b1, mosi_oe_n: 1'b1, miso_s1: 1'b1,
                   miso_s2: 1'b1, cmd_rdy: 1'b0, tx_rdy: 1'b0, rx_data: RX_RST,
                   rx_valid: 1'b0, session: 1'b0};
      end else begin
         q_ff <= nxt_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pins and user outputs

   assign link.power_en = q_ff.power;
   assign link.rst_out = q_ff.rst_out;
   assign link.rst_oe_n = q_ff.rst_oe_n;
   assign link.ss_out = q_ff.ss_out;
   assign link.ss_oe_n = q_ff.ss_oe_n;
   assign link.sck_out = q_ff.sck;
   assign link.sck_oe_n = q_ff.sck_oe_n;
   assign link.mosi_out = q_ff.sh[7];
   assign link.mosi_oe_n = q_ff.mosi_oe_n;
   assign cmd_ready_o = q_ff.cmd_rdy;
   assign tx_ready_o = q_ff.tx_rdy;
   assign rx_data_o = q_ff.rx_data;
   assign rx_valid_o = q_ff.rx_valid;
   assign session_o = q_ff.session;
endmodule

/* File: tb/isp_link_properties.sv */
module isp_link_properties
   import isp_pkg::*;
#(
   parameter int unsigned STARTUP_CYC = STARTUP_CYC_DEF
)
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic power_en,
   input wire logic ss_oe_n,
   input wire logic sck_oe_n,
   input wire logic mosi_oe_n,
   input wire logic miso_oe_n,
   input wire logic rst_lvl,
   input wire logic ss_lvl,
   input wire logic sck_lvl,
   input wire logic mosi_lvl,
   input wire logic miso_lvl
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [11:0] pwr_cnt_ff;
   logic [11:0] ss_hi_cnt_ff;
   logic [11:0] sck_lo_cnt_ff;
   logic [11:0] rst_lo_cnt_ff;

   // Saturating, so a long session never wraps into a short count
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pwr_cnt_ff <= 12'h000;
         ss_hi_cnt_ff <= 12'h000;
         sck_lo_cnt_ff <= 12'h000;
         rst_lo_cnt_ff <= 12'h000;
      end else begin
         pwr_cnt_ff <= !power_en ? 12'h000 : pwr_cnt_ff + {11'h000, ~&pwr_cnt_ff};
         ss_hi_cnt_ff <= !ss_lvl ? 12'h000 : ss_hi_cnt_ff + {11'h000, ~&ss_hi_cnt_ff};
         sck_lo_cnt_ff <= sck_lvl ? 12'h000 : sck_lo_cnt_ff + {11'h000, ~&sck_lo_cnt_ff};
         rst_lo_cnt_ff <= rst_lvl ? 12'h000 : rst_lo_cnt_ff + {11'h000, ~&rst_lo_cnt_ff};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   sequence s_sck_high;
      sck_lvl[*8] ##1 sck_lvl ##1 sck_lvl ##1 !sck_lvl;
   endsequence
   sequence s_sck_low;
      !sck_lvl[*8] ##1 !sck_lvl ##1 !sck_lvl;
   endsequence

   property p_sck_idle;
      ss_lvl |-> !sck_lvl;
   endproperty
   a_sck_idle: assert property (p_sck_idle) else $error("clock not low while deselected");
   property p_mosi_hold;
      !ss_lvl && sck_lvl |-> $stable(mosi_lvl);
   endproperty
   a_mosi_hold: assert property (p_mosi_hold) else $error("data moved while clock high");
   // Link reset at deselect may move the output, hence the select guard
   property p_miso_edge;
      !ss_lvl && $past(!ss_lvl) && !miso_oe_n && $past(!miso_oe_n) && $changed(miso_lvl)
         |-> $fell(sck_lvl);
   endproperty
   a_miso_edge: assert property (p_miso_edge) else $error("reply moved off falling edge");
   property p_sck_high;
      $rose(sck_lvl) |-> s_sck_high;
   endproperty
   a_sck_high: assert property (p_sck_high) else $error("clock high time wrong");
   property p_sck_low;
      $fell(sck_lvl) && !ss_lvl |-> s_sck_low;
   endproperty
   a_sck_low: assert property (p_sck_low) else $error("clock low time short");
   property p_pwr_rst;
      $rose(power_en) |-> !rst_lvl[*8];
   endproperty
   a_pwr_rst: assert property (p_pwr_rst) else $error("reset not low at power on");
   property p_pwr_wait;
      $rose(ss_lvl) && !rst_lvl |-> pwr_cnt_ff >= PWRUP_CYC;
   endproperty
   a_pwr_wait: assert property (p_pwr_wait) else $error("select raised too early");
   property p_startup;
      $fell(ss_lvl) && !rst_lvl && $past(power_en) && pwr_cnt_ff < 12'h44c
         |-> ss_hi_cnt_ff >= STARTUP_CYC;
   endproperty
   a_startup: assert property (p_startup) else $error("session before start-up timeout");
   property p_entry;
      // Select idles high, so settling is counted from reset low
      $fell(ss_lvl) && !rst_lvl && $past(power_en) |-> rst_lo_cnt_ff >= ENTRY_CYC;
   endproperty
   a_entry: assert property (p_entry) else $error("entry settle too short");
   property p_lag;
      $rose(ss_lvl) |-> sck_lo_cnt_ff >= SSD_CYC;
   endproperty
   a_lag: assert property (p_lag) else $error("select raised before lag");
   property p_release;
      $rose(rst_lvl) && power_en |-> ss_hi_cnt_ff >= SSZ_CYC && sck_oe_n && mosi_oe_n
         ##[0:2] ss_oe_n;
   endproperty
   a_release: assert property (p_release) else $error("exit order broken");
   property p_pwr_off;
      $fell(power_en) |-> ss_oe_n && sck_oe_n && mosi_oe_n;
   endproperty
   a_pwr_off: assert property (p_pwr_off) else $error("power cut with pins driven");
endmodule

/* File: tb/testbench.sv */
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import isp_pkg::*;
   // Short hold counts keep the run small
   localparam int STARTUP = 30;
   localparam int WR = 50;
   localparam int WR_AE = 60;
   localparam int ERS = 70;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic dev_rst_n;
   logic cfg_rst_pin_en = 1'b1;
   logic cfg_isp_en = 1'b0;
   logic [7:0] reply = 8'h00;
   logic reply_load = 1'b0;
   isp_cmd_t cmd = CMD_PWRUP;
   logic cmd_valid = 1'b0;
   logic [7:0] tx_byte = 8'h00;
   isp_wait_t tx_wait = WAIT_NONE;
   logic tx_valid = 1'b0;
   logic cmd_ready, tx_ready, session, prg_rx_valid, dev_rx_valid, prog_mode, cpu_run, io_tri;
   logic [7:0] prg_rx, dev_rx, wire_sh;
   logic [7:0] dev_q[$], prg_q[$], wire_q[$];
   logic sck_prev = 1'b0;
   int wire_cnt = 0;
   int err_total = 0;
   int check_count = 0;

   isp_if link_if();
   always #5 clk_i = ~clk_i;
   // Supply doubles as the device's power-on reset
   assign dev_rst_n = rst_n_i & link_if.power_en;

   isp_dev isp_dev_i (
      .clk_i(clk_i), .rst_n_i(dev_rst_n), .link(link_if.dev),
      .cfg_rst_pin_en_i(cfg_rst_pin_en), .cfg_isp_en_i(cfg_isp_en),
      .tx_data_i(reply), .tx_load_i(reply_load), .rx_data_o(dev_rx),
      .rx_valid_o(dev_rx_valid), .prog_mode_o(prog_mode), .cpu_run_o(cpu_run),
      .io_tristate_o(io_tri)
   );
   isp_prg #(.STARTUP_CYC(STARTUP), .WR_CYC(WR), .WR_AE_CYC(WR_AE), .ERS_CYC(ERS)) isp_prg_i (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .link(link_if.prg), .cmd_i(cmd),
      .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .tx_data_i(tx_byte),
      .tx_wait_i(tx_wait), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready),
      .rx_data_o(prg_rx), .rx_valid_o(prg_rx_valid), .session_o(session)
   );
   isp_link_properties #(.STARTUP_CYC(STARTUP)) isp_link_properties_i (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .power_en(link_if.power_en),
      .ss_oe_n(link_if.ss_oe_n), .sck_oe_n(link_if.sck_oe_n), .mosi_oe_n(link_if.mosi_oe_n),
      .miso_oe_n(link_if.miso_oe_n), .rst_lvl(link_if.rst_lvl), .ss_lvl(link_if.ss_lvl),
      .sck_lvl(link_if.sck_lvl), .mosi_lvl(link_if.mosi_lvl), .miso_lvl(link_if.miso_lvl)
   );

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic await(ref logic sig, input logic val, input int lim);
      int n;
      n = 0;
      while (sig !== val && n < lim) begin
         @(negedge clk_i);
         n++;
      end
      if (sig !== val) begin
         err_total++;
         $display("CHECK FAILED at %0t: wait ran out", $time);
      end
   endtask

   function automatic logic [7:0] mode();
      return {5'h00, prog_mode, cpu_run, io_tri};
   endfunction

   task automatic do_cmd(input isp_cmd_t c, input logic sess);
      cmd = c;
      cmd_valid = 1'b1;
      await(cmd_ready, 1'b1, 50);
      @(negedge clk_i);
      cmd_valid = 1'b0;
      await(session, sess, 2000);
      // Margin for the device's pin synchronisers
      repeat (12) @(negedge clk_i);
   endtask

   // Each new frame starts with a zero reply
   task automatic new_frame();
      prg_q.delete();
      prg_q.push_back(8'h00);
   endtask

   task automatic xfer(input logic [7:0] b, input isp_wait_t w);
      int n;
      int h;
      n = 0;
      h = (w == WAIT_WR) ? WR : (w == WAIT_WR_AE) ? WR_AE : (w == WAIT_ERS) ? ERS : 0;
      tx_byte = b;
      tx_wait = w;
      tx_valid = 1'b1;
      dev_q.push_back(b);
      wire_q.push_back(b);
      await(tx_ready, 1'b1, 50);
      @(negedge clk_i);
      tx_valid = 1'b0;
      await(prg_rx_valid, 1'b1, 300);
      while (tx_ready !== 1'b1 && n < 1000) begin
         @(negedge clk_i);
         n++;
      end
      chk({7'h00, n >= h && n <= h + 4}, 8'h01);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   always @(negedge clk_i) begin
      reply_load = (dev_rx_valid === 1'b1);
      if (dev_rx_valid === 1'b1) begin
         reply = 8'($urandom);
         prg_q.push_back(reply);
         chk(dev_rx, (dev_q.size() > 0) ? dev_q.pop_front() : 8'hxx);
      end
      if (prg_rx_valid === 1'b1) begin
         chk(prg_rx, (prg_q.size() > 0) ? prg_q.pop_front() : 8'hxx);
      end
      if (link_if.sck_lvl && !sck_prev && !link_if.ss_lvl) begin
         wire_sh = {wire_sh[6:0], link_if.mosi_lvl};
         wire_cnt++;
      end
      if (wire_cnt == 8) begin
         chk(wire_sh, (wire_q.size() > 0) ? wire_q.pop_front() : 8'hxx);
         wire_cnt = 0;
      end
      sck_prev = link_if.sck_lvl;
   end

   initial begin
      repeat (20000) @(posedge clk_i);
      err_total++;
      $display("CHECK FAILED at %0t: run hung", $time);
      summarize();
   end

   initial begin
      void'($urandom(32'hb4512dd3));
      repeat (10) @(negedge clk_i);
      rst_n_i = 1'b1;
      @(negedge clk_i);
      do_cmd(CMD_PWRUP, 1'b1);
      chk(mode(), 8'h05);
      cfg_isp_en = 1'b1;
      new_frame();
      for (int i = 0; i < 4; i++) begin
         xfer(8'($urandom), isp_wait_t'(i));
      end
      do_cmd(CMD_EXIT, 1'b0);
      chk(mode(), 8'h02);
      do_cmd(CMD_START, 1'b1);
      chk(mode(), 8'h05);
      cfg_isp_en = 1'b0;
      new_frame();
      xfer(8'h80, WAIT_NONE);
      xfer(8'h01, WAIT_NONE);
      xfer(8'($urandom), WAIT_NONE);
      do_cmd(CMD_EXIT, 1'b0);
      do_cmd(CMD_START, 1'b1);
      chk(mode(), 8'h00);
      do_cmd(CMD_EXIT, 1'b0);
      chk(mode(), 8'h02);
      do_cmd(CMD_PWRDN, 1'b0);
      chk({7'h00, link_if.power_en}, 8'h00);
      chk(mode(), 8'h00);
      cfg_rst_pin_en = 1'b0;
      do_cmd(CMD_PWRUP, 1'b1);
      chk(mode(), 8'h05);
      new_frame();
      xfer(8'($urandom), WAIT_WR);
      xfer(8'($urandom), WAIT_NONE);
      do_cmd(CMD_EXIT, 1'b0);
      do_cmd(CMD_START, 1'b1);
      chk(mode(), 8'h02);
      do_cmd(CMD_PWRDN, 1'b0);
      chk(mode(), 8'h00);
      summarize();
   end
endmodule
